// ===== shared/adcr_pkg.sv
// Package with register map, fields, reset values and timing of the converter control block
`default_nettype none

package adcr_pkg;

    // ==========================================
    // Register offsets
    localparam logic [7:0] OFF_RES_LO  = 8'h78;
    localparam logic [7:0] OFF_RES_HI  = 8'h79;
    localparam logic [7:0] OFF_CTRL_A  = 8'h7A;
    localparam logic [7:0] OFF_CTRL_B  = 8'h7B;
    localparam logic [7:0] OFF_IN_SEL  = 8'h7C;
    localparam logic [7:0] OFF_BUF_DIS = 8'h7E;

    // ==========================================
    // Field positions
    localparam int BIT_ON       = 7;
    localparam int BIT_BEGIN    = 6;
    localparam int BIT_AUTO     = 5;
    localparam int BIT_DONE     = 4;
    localparam int BIT_IE       = 3;
    localparam int BIT_LEFT     = 5;
    localparam int REF_LSB      = 6;
    localparam int DIV_LSB      = 0;
    localparam int TRIG_LSB     = 0;
    localparam int CHAN_LSB     = 0;
    localparam int BUF_LSB      = 0;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_CTRL_A  = 8'h00;
    localparam logic [7:0] RST_CTRL_B  = 8'h00;
    localparam logic [7:0] RST_IN_SEL  = 8'h00;
    localparam logic [7:0] RST_BUF_DIS = 8'h00;
    localparam logic [9:0] RST_RESULT  = 10'h000;

    // ==========================================
    // Timing in converter clock cycles
    localparam logic [4:0] FIRST_CONV_CYCLES = 5'h19;
    localparam logic [4:0] NORM_CONV_CYCLES  = 5'h0D;

    // ==========================================
    // Encodings
    typedef enum logic [1:0] {
        REF_EXT_PIN  = 2'b00,
        REF_SUPPLY   = 2'b01,
        REF_RESERVED = 2'b10,
        REF_INT_1V1  = 2'b11
    } adcr_ref_t;

    typedef enum logic [3:0] {
        CH_TEMP     = 4'b1000,
        CH_BANDGAP  = 4'b1110,
        CH_GROUND   = 4'b1111
    } adcr_chan_t;

    typedef enum logic [2:0] {
        TRIG_FREE     = 3'b000,
        TRIG_COMP     = 3'b001,
        TRIG_EXT0     = 3'b010,
        TRIG_T0_CMPA  = 3'b011,
        TRIG_T0_OVF   = 3'b100,
        TRIG_T1_CMPB  = 3'b101,
        TRIG_T1_OVF   = 3'b110,
        TRIG_T1_CAPT  = 3'b111
    } adcr_trig_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } adcr_state_t;

    // ==========================================
    // Setting handed to the analog section
    typedef struct packed {
        logic       active;
        logic       first;
        logic [1:0] reference;
        logic [3:0] channel;
    } adcr_conv_t;

endpackage

`default_nettype wire

// ===== hdl/adcr_top.sv
// Converter control registers, sequencing, result view and pin buffer gating
//
// Function
// R1: Two-bit reference field picks external pin, supply, reserved or internal 1.1V.
// R2: Reference and channel changes wait until the running conversion completes.
// R3: Justify bit selects left or right view; change is seen at once.
// R4: Bit 4 of input selection always reads zero.
// R5: Four-bit channel field picks inputs 0-7, temperature, bandgap or ground.
// R6: Enable bit turns converter on; clearing it aborts any conversion.
// R7: Start bit begins each single conversion, only the first in free running.
// R8: First conversion after enable takes 25 converter cycles, later ones 13.
// R9: Start bit reads one while converting; writing zero does nothing.
// R10: With auto trigger on, each rising trigger edge starts a conversion.
// R11: Done flag sets on completion; interrupt when flag, enable, global enable.
// R12: Done flag clears on vector execution or when software writes one.
// R13: Prescaler divides system clock by 2,2,4,8,16,32,64,128.
// R14: Result bytes placed right or left justified; unused bits read zero.
// R15: Reading low byte blocks result updates until high byte is read.
// R16: Trigger source field selects among free running and seven flags.
// R17: Trigger source has no effect while auto trigger is off.
// R18: Switching to a source whose flag is set makes a rising edge.
// R19: Switching to free running code never makes a trigger event.
// R20: Input buffer off bits force matching pin inputs to read zero.
// R21: Software writes zero to reserved bits of those registers.
// R22: Result is input times 1024 over reference, 10 bits wide.
// R23: Free running restarts a conversion right after each completion.
// R24: Data update, flag set and start bit clear share one cycle.
//
// The address-and-strobe port was left to the implementer.
`default_nettype none

module adcr_top (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    // Register port
    input  wire logic [7:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [7:0]            o_rdata,
    // Analog section
    input  wire logic [9:0]            i_sample,
    output adcr_pkg::adcr_conv_t       o_conv,
    // Trigger flags 1 to 7
    input  wire logic [7:1]            i_trig_flags,
    // Interrupt
    input  wire logic                  i_global_ie,
    input  wire logic                  i_vector_ack,
    output logic                       o_irq,
    // Digital pins
    input  wire logic [5:0]            i_pin_raw,
    output logic      [5:0]            o_pin_in
);

    // ==========================================
    // Decoding
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [6:0] div_mask(input logic [2:0] code);
        logic [6:0] m;
        m = 7'h01;
        case (code)
            3'h2:    m = 7'h03;
            3'h3:    m = 7'h07;
            3'h4:    m = 7'h0F;
            3'h5:    m = 7'h1F;
            3'h6:    m = 7'h3F;
            3'h7:    m = 7'h7F;
            default: m = 7'h01;
        endcase
        div_mask = m;
    endfunction

    // ==========================================
    // Registers
    logic [7:0]            in_sel_q;
    logic                  on_q;
    logic                  auto_q;
    logic                  flag_q;
    logic                  ie_q;
    logic [2:0]            div_q;
    logic [2:0]            trig_q;
    logic [5:0]            buf_q;
    logic [9:0]            res_q;
    logic                  lock_q;
    logic                  first_q;
    logic                  trig_prev_q;
    logic [6:0]            div_cnt_q;
    logic [4:0]            cnt_q;
    logic [4:0]            len_q;
    logic [1:0]            cur_ref_q;
    logic [3:0]            cur_chan_q;
    logic [7:0]            rdata_q;
    adcr_pkg::adcr_state_t state_q;
    adcr_pkg::adcr_state_t state_d;
    logic [5:0]            sync1_q;
    logic [5:0]            sync2_q;
    logic [5:0]            sync3_q;
    logic [5:0]            pin_st_q;
    logic [5:0]            pin_out_q;

    // ==========================================
    // Write and read decode
    wire wr_a    = i_wr & hit(i_addr, adcr_pkg::OFF_CTRL_A);
    wire wr_b    = i_wr & hit(i_addr, adcr_pkg::OFF_CTRL_B);
    wire wr_sel  = i_wr & hit(i_addr, adcr_pkg::OFF_IN_SEL);
    wire wr_buf  = i_wr & hit(i_addr, adcr_pkg::OFF_BUF_DIS);
    wire rd_lo   = i_rd & hit(i_addr, adcr_pkg::OFF_RES_LO);
    wire rd_hi   = i_rd & hit(i_addr, adcr_pkg::OFF_RES_HI);

    // ==========================================
    // Sequencing
    wire busy     = (state_q == adcr_pkg::ST_CONV);
    wire en_next  = wr_a ? i_wdata[adcr_pkg::BIT_ON] : on_q;                 // see R6
    wire sw_start = wr_a & i_wdata[adcr_pkg::BIT_BEGIN];                     // see R7 R9
    wire [7:0] trig_src = {i_trig_flags, 1'b0};                              // see R16 R19
    wire trig_sig   = trig_src[trig_q];
    wire trig_edge  = trig_sig & ~trig_prev_q;                               // see R18
    wire auto_start = auto_q & trig_edge;                                    // see R10 R17
    wire free_mode  = auto_q & (trig_q == adcr_pkg::TRIG_FREE);
    wire [6:0] mask = div_mask(div_q);
    wire tick       = on_q & ((div_cnt_q & mask) == mask);                   // see R13
    wire done       = busy & en_next & tick & (cnt_q == len_q - 5'h01);
    wire restart    = done & free_mode;                                      // see R23
    wire go         = ~busy & en_next & (sw_start | auto_start);
    wire first_go   = first_q | ~on_q;                                       // see R8
    wire load_sel   = ~busy | done;                                          // see R2
    wire block_upd  = lock_q | rd_lo;                                        // see R15

    always_comb begin
        state_d = state_q;
        case (state_q)
            adcr_pkg::ST_IDLE: begin
                if (go) begin
                    state_d = adcr_pkg::ST_CONV;
                end
            end
            adcr_pkg::ST_CONV: begin
                if (!en_next) begin
                    state_d = adcr_pkg::ST_IDLE;                             // see R6
                end else if (done && !restart) begin
                    state_d = adcr_pkg::ST_IDLE;                             // see R24
                end
            end
            default: state_d = adcr_pkg::ST_IDLE;
        endcase
    end

    // ==========================================
    // Result view
    wire left = in_sel_q[adcr_pkg::BIT_LEFT];                                // see R3
    wire [7:0] lo_view = left ? {res_q[1:0], 6'h00} : res_q[7:0];            // see R14
    wire [7:0] hi_view = left ? res_q[9:2] : {6'h00, res_q[9:8]};            // see R14
    wire [7:0] ctrl_a_view = {on_q, busy, auto_q, flag_q, ie_q, div_q};      // see R9
    wire [7:0] rd_mux =
        hit(i_addr, adcr_pkg::OFF_RES_LO)  ? lo_view :
        hit(i_addr, adcr_pkg::OFF_RES_HI)  ? hi_view :
        hit(i_addr, adcr_pkg::OFF_CTRL_A)  ? ctrl_a_view :
        hit(i_addr, adcr_pkg::OFF_CTRL_B)  ? {5'h00, trig_q} :
        hit(i_addr, adcr_pkg::OFF_IN_SEL)  ? in_sel_q :
        hit(i_addr, adcr_pkg::OFF_BUF_DIS) ? {2'h0, buf_q} :
        8'h00;

    // ==========================================
    // Control registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            in_sel_q <= adcr_pkg::RST_IN_SEL;
            trig_q   <= adcr_pkg::RST_CTRL_B[2:0];
            buf_q    <= adcr_pkg::RST_BUF_DIS[5:0];
            on_q     <= adcr_pkg::RST_CTRL_A[adcr_pkg::BIT_ON];
            auto_q   <= adcr_pkg::RST_CTRL_A[adcr_pkg::BIT_AUTO];
            ie_q     <= adcr_pkg::RST_CTRL_A[adcr_pkg::BIT_IE];
            div_q    <= adcr_pkg::RST_CTRL_A[2:0];
        end else begin
            if (wr_sel) begin
                in_sel_q <= i_wdata & 8'hEF;                                 // see R1 R4 R5
            end
            if (wr_b) begin
                trig_q <= i_wdata[2:0];                                      // see R16
            end
            if (wr_buf) begin
                buf_q <= i_wdata[5:0];                                       // see R20
            end
            if (wr_a) begin
                on_q   <= i_wdata[adcr_pkg::BIT_ON];
                auto_q <= i_wdata[adcr_pkg::BIT_AUTO];
                ie_q   <= i_wdata[adcr_pkg::BIT_IE];
                div_q  <= i_wdata[2:0];
            end
        end
    end

    // ==========================================
    // Conversion engine
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q     <= adcr_pkg::ST_IDLE;
            div_cnt_q   <= 7'h00;
            cnt_q       <= 5'h00;
            len_q       <= adcr_pkg::NORM_CONV_CYCLES;
            first_q     <= 1'b0;
            trig_prev_q <= 1'b0;
            cur_ref_q   <= 2'h0;
            cur_chan_q  <= 4'h0;
        end else begin
            state_q     <= state_d;
            trig_prev_q <= trig_sig;
            div_cnt_q   <= en_next ? div_cnt_q + 7'h01 : 7'h00;
            if (go) begin
                first_q <= 1'b0;
                cnt_q   <= 5'h00;
                len_q   <= first_go ? adcr_pkg::FIRST_CONV_CYCLES     // see R8
                                    : adcr_pkg::NORM_CONV_CYCLES;
            end else if (restart) begin
                cnt_q <= 5'h00;
                len_q <= adcr_pkg::NORM_CONV_CYCLES;
            end else begin
                if (busy && tick) begin
                    cnt_q <= cnt_q + 5'h01;
                end
                if (!on_q && en_next) begin
                    first_q <= 1'b1;
                end
            end
            if (load_sel) begin
                cur_ref_q  <= in_sel_q[7:6];                                 // see R2
                cur_chan_q <= in_sel_q[3:0];                                 // see R2
            end
        end
    end

    // ==========================================
    // Result, lock and flag
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            res_q  <= adcr_pkg::RST_RESULT;
            lock_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            if (done && !block_upd) begin
                res_q <= i_sample;                                           // see R22 R24
            end
            if (rd_hi) begin
                lock_q <= 1'b0;
            end else if (rd_lo) begin
                lock_q <= 1'b1;                                              // see R15
            end
            if (done) begin
                flag_q <= 1'b1;                                              // see R11 R24
            end else if (i_vector_ack || (wr_a && i_wdata[adcr_pkg::BIT_DONE])) begin
                flag_q <= 1'b0;                                              // see R12
            end
        end
    end

    // ==========================================
    // Read data
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= i_rd ? rd_mux : 8'h00;
        end
    end

    // ==========================================
    // Pin input synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_pin
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    sync1_q[gi]   <= 1'b0;
                    sync2_q[gi]   <= 1'b0;
                    sync3_q[gi]   <= 1'b0;
                    pin_st_q[gi]  <= 1'b0;
                    pin_out_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= i_pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        pin_st_q[gi] <= sync3_q[gi];
                    end
                    pin_out_q[gi] <= pin_st_q[gi] & ~buf_q[gi];             // see R20
                end
            end
        end
    endgenerate

    // ==========================================
    // Outputs
    assign o_rdata          = rdata_q;
    assign o_pin_in         = pin_out_q;
    assign o_irq            = flag_q & ie_q & i_global_ie;                   // see R11
    wire   conv_first       = (len_q == adcr_pkg::FIRST_CONV_CYCLES);
    assign o_conv           = {busy, conv_first, cur_ref_q, cur_chan_q};     // see R1 R5

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    property p_done_flag;
        done |=> flag_q && (!busy || $past(restart));
    endproperty
    a_done_flag: assert property (p_done_flag)                               // see R11 R24
        else $error("flag not set or start not cleared at completion");

    property p_abort;
        busy && wr_a && !i_wdata[adcr_pkg::BIT_ON] |=> !busy && !$rose(flag_q);
    endproperty
    a_abort: assert property (p_abort)                                       // see R6
        else $error("disable did not abort conversion");

    property p_hold_sel;
        busy && !done |=> $stable(cur_chan_q) && $stable(cur_ref_q);
    endproperty
    a_hold_sel: assert property (p_hold_sel)                                 // see R2
        else $error("setting changed during conversion");

    property p_busy_read;
        i_rd && hit(i_addr, adcr_pkg::OFF_CTRL_A) |=> o_rdata[6] == $past(busy);
    endproperty
    a_busy_read: assert property (p_busy_read)                               // see R9
        else $error("start bit read does not show conversion state");

    property p_rsv_read;
        i_rd && hit(i_addr, adcr_pkg::OFF_IN_SEL) |=> o_rdata[4] == 1'b0;
    endproperty
    a_rsv_read: assert property (p_rsv_read)                                 // see R4
        else $error("reserved bit read as one");

    property p_lock;
        lock_q && !rd_hi |=> $stable(res_q);
    endproperty
    a_lock: assert property (p_lock)                                         // see R15
        else $error("result changed while locked");

    property p_irq;
        done && ie_q && i_global_ie |=> o_irq || !ie_q || !i_global_ie;
    endproperty
    a_irq: assert property (p_irq)                                           // see R11
        else $error("interrupt not raised after completion");

    property p_free;
        done && free_mode |=> busy && cnt_q == 5'h00;
    endproperty
    a_free: assert property (p_free)                                         // see R23
        else $error("free running did not restart");

    property p_no_auto;
        !auto_q && !sw_start && !busy |=> !busy;
    endproperty
    a_no_auto: assert property (p_no_auto)                                   // see R17
        else $error("conversion started without request");

    property p_free_sel;
        wr_b && i_wdata[2:0] == adcr_pkg::TRIG_FREE && !busy && !go |=> !busy;
    endproperty
    a_free_sel: assert property (p_free_sel)                                 // see R19
        else $error("free running code made a trigger edge");

    property p_pin_off;
        ##1 $stable(buf_q) |-> (o_pin_in & buf_q) == 6'h00;
    endproperty
    a_pin_off: assert property (p_pin_off)                                   // see R20
        else $error("disabled pin input reads one");

    property p_first_len;
        go && first_go |=> len_q == adcr_pkg::FIRST_CONV_CYCLES;
    endproperty
    a_first_len: assert property (p_first_len)                               // see R8
        else $error("first conversion length wrong");

    c_single: cover property (go ##[1:400] done);
    c_free:   cover property (restart);
    c_trig:   cover property (auto_start && trig_q != adcr_pkg::TRIG_FREE);
    c_lock:   cover property (done && block_upd);

endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking testbench for the converter control block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Signals
    logic                 i_clk;
    logic                 i_sys_rst;
    logic [7:0]           i_addr;
    logic [7:0]           i_wdata;
    logic                 i_wr;
    logic                 i_rd;
    logic [7:0]           o_rdata;
    logic [9:0]           i_sample;
    adcr_pkg::adcr_conv_t conv_w;
    logic [7:1]           i_trig_flags;
    logic                 i_global_ie;
    logic                 i_vector_ack;
    logic                 o_irq;
    logic [5:0]           i_pin_raw;
    logic [5:0]           o_pin_in;
    logic [7:0]           exp_q[$];
    logic                 rd_seen;
    logic                 act_d;
    int                   fails;
    int                   n_tests;
    int                   n_starts;
    int                   cnt;
    int                   last_len;
    int                   seed;
    int                   n0;
    logic [9:0]           sa;
    logic [9:0]           sb;
    logic [9:0]           sc;

    adcr_top dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sample(i_sample), .o_conv(conv_w),
        .i_trig_flags(i_trig_flags), .i_global_ie(i_global_ie), .i_vector_ack(i_vector_ack),
        .o_irq(o_irq), .i_pin_raw(i_pin_raw), .o_pin_in(o_pin_in));

    // ==========================================
    // Clock, monitor and conversion counters
    always #5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        rd_seen <= i_rd;
        act_d   <= conv_w.active;
        if (conv_w.active && !act_d) n_starts++;
        if (conv_w.active) cnt++;
        else if (act_d) begin
            last_len = cnt;
            cnt = 0;
        end
    end

    always @(negedge i_clk) begin
        if (rd_seen === 1'b1) chk(o_rdata, exp_q.pop_front());
    end

    // ==========================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        @(negedge i_clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic wait_idle;
        int k;
        k = 0;
        @(negedge i_clk);
        while (conv_w.active === 1'b1 && k < 3000) begin
            @(negedge i_clk);
            k++;
        end
        cyc(2);
    endtask

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        print_verdict();
    end

    // ==========================================
    // Main sequence
    initial begin
        i_clk = 0; i_sys_rst = 1; i_addr = 0; i_wdata = 0; i_wr = 0; i_rd = 0;
        i_sample = 0; i_trig_flags = 0; i_global_ie = 1; i_vector_ack = 0; i_pin_raw = 0;
        fails = 0; n_tests = 0; n_starts = 0; cnt = 0; last_len = 0; seed = 32'he1ee;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int b = 0; b < 7; b++) rd(8'h78 + 8'(b), 8'h00);
        endt("reset");
        wr(8'h7C, 8'hFF); rd(8'h7C, 8'hEF);
        wr(8'h7B, 8'h47); rd(8'h7B, 8'h07);
        wr(8'h7E, 8'h3F); rd(8'h7E, 8'h3F);
        wr(8'h7B, 8'h00); wr(8'h7E, 8'h15); wr(8'h7C, 8'hC5);
        cyc(2);
        chk({2'b00, conv_w.reference, conv_w.channel}, 8'h35);
        endt("fields");
        @(posedge i_clk) i_pin_raw <= 6'($random(seed));
        cyc(8);
        chk({2'b00, o_pin_in}, {2'b00, i_pin_raw & ~6'h15});
        endt("pins");
        sa = 10'($random(seed));
        @(posedge i_clk) i_sample <= sa;
        wr(8'h7A, 8'hC8); wait_idle();
        chk_rng(last_len, 48, 51);
        rd(8'h7A, 8'h98);
        chk({7'h00, o_irq}, 8'h01);
        @(posedge i_clk) i_global_ie <= 1'b0;
        cyc(1); chk({7'h00, o_irq}, 8'h00);
        @(posedge i_clk) i_global_ie <= 1'b1;
        rd(8'h78, sa[7:0]); rd(8'h79, {6'h00, sa[9:8]});
        wr(8'h7C, 8'hE5);
        rd(8'h78, {sa[1:0], 6'h00}); rd(8'h79, sa[9:2]);
        wr(8'h7A, 8'h98); rd(8'h7A, 8'h88);
        endt("single");
        sb = 10'($random(seed));
        @(posedge i_clk) i_sample <= sb;
        wr(8'h7A, 8'hCB); rd(8'h7A, 8'hCB);
        wr(8'h7A, 8'h8B); wr(8'h7C, 8'h68); rd(8'h7A, 8'hCB);
        chk({2'b00, conv_w.reference, conv_w.channel}, 8'h35);
        wait_idle();
        chk_rng(last_len, 102, 105);
        chk({2'b00, conv_w.reference, conv_w.channel}, 8'h18);
        rd(8'h7A, 8'h9B);
        @(posedge i_clk) i_vector_ack <= 1'b1;
        @(posedge i_clk) i_vector_ack <= 1'b0;
        rd(8'h7A, 8'h8B); chk({7'h00, o_irq}, 8'h00);
        rd(8'h78, {sb[1:0], 6'h00});
        endt("deferral");
        sc = 10'($random(seed));
        @(posedge i_clk) i_sample <= sc;
        wr(8'h7A, 8'hC8); wait_idle();
        chk_rng(last_len, 24, 27);
        rd(8'h79, sb[9:2]);
        wr(8'h7A, 8'hD8); wait_idle();
        rd(8'h79, sc[9:2]);
        endt("lock");
        wr(8'h7A, 8'hC8); cyc(10); wr(8'h7A, 8'h18); cyc(3);
        chk({7'h00, conv_w.active}, 8'h00);
        cyc(60); rd(8'h7A, 8'h08);
        endt("abort");
        wr(8'h7A, 8'hA8);
        for (int s = 1; s < 8; s++) begin
            wr(8'h7B, 8'(s));
            n0 = n_starts;
            @(posedge i_clk) i_trig_flags <= 7'(1 << (s - 1));
            cyc(4); chk_rng(n_starts, n0 + 1, n0 + 1);
            wait_idle();
            @(posedge i_clk) i_trig_flags <= 7'h00;
        end
        n0 = n_starts;
        @(posedge i_clk) i_trig_flags <= 7'h02;
        cyc(4); chk_rng(n_starts, n0, n0);
        wr(8'h7B, 8'h02); cyc(4); chk_rng(n_starts, n0 + 1, n0 + 1);
        wait_idle();
        @(posedge i_clk) i_trig_flags <= 7'h00;
        n0 = n_starts;
        wr(8'h7B, 8'h00); cyc(10); chk_rng(n_starts, n0, n0);
        wr(8'h7A, 8'h88); wr(8'h7B, 8'h01);
        @(posedge i_clk) i_trig_flags <= 7'h01;
        cyc(10); chk_rng(n_starts, n0, n0);
        @(posedge i_clk) i_trig_flags <= 7'h00;
        endt("trigger");
        wr(8'h7B, 8'h00); wr(8'h7A, 8'hE8); cyc(120);
        wr(8'h7A, 8'hF8); cyc(60);
        chk({7'h00, o_irq}, 8'h01);
        wr(8'h7A, 8'h00);
        endt("free_run");
        print_verdict();
    end

endmodule

`default_nettype wire
